// *** rtl/sfp_pkg.sv ***
// shared types, reset values and lane decoding for the serial flash pin front end
`default_nettype none
package sfp_pkg;

   // ==================================================
   // lane width of the current transfer phase
   typedef enum logic [1:0] {
      SFP_SINGLE = 2'h0,
      SFP_DUAL   = 2'h1,
      SFP_QUAD   = 2'h2
   } sfp_width_e;

   // ==================================================
   // protected status field layout and reset values
   localparam int         STATUS_W     = 6;
   localparam int         ST_SWD       = 5;
   localparam int         ST_QE        = 4;
   localparam int         ST_BP_LSB    = 0;
   localparam logic [5:0] STATUS_RST   = 6'h00;
   localparam logic [3:0] BIT_CNT_RST  = 4'h0;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [7:0] BYTE_RST     = 8'h00;
   localparam logic [3:0] LANE_RST     = 4'h0;

   // ==================================================
   // pin function decoding
   function automatic logic ded_reset_on(input logic hasDed, input logic dedDisable);
      ded_reset_on = hasDed && !dedDisable;
   endfunction : ded_reset_on

   // shared pin acts as reset only with quad off, dedicated reset not enabled and the select bit set
   function automatic logic pin3_is_reset(input logic qe, input logic hasDed, input logic dedDisable,
                                          input logic sel);
      pin3_is_reset = !qe && !ded_reset_on(hasDed, dedDisable) && sel;
   endfunction : pin3_is_reset

   // ==================================================
   // shifting arithmetic
   function automatic logic [3:0] width_step(input sfp_width_e w);
      case (w)
         SFP_DUAL: width_step = 4'h2;
         SFP_QUAD: width_step = 4'h4;
         default:  width_step = 4'h1;
      endcase
   endfunction : width_step

   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] lanes, input sfp_width_e w);
      case (w)
         SFP_DUAL: shift_in = {sh[5:0], lanes[1:0]};
         SFP_QUAD: shift_in = {sh[3:0], lanes[3:0]};
         default:  shift_in = {sh[6:0], lanes[0]};
      endcase
   endfunction : shift_in

endpackage : sfp_pkg
`default_nettype wire

// *** rtl/sfp_sync2.sv ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none

module sfp_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // level in and out
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   // ==================================================
   // first stage is read by the second stage only
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : sfp_sync2

`default_nettype wire

// *** rtl/sfp_pin_ctrl.sv ***
// serial flash pin front end: select, lane capture and drive, pin function muxing, status protection
//
// How it works
// - chip select high deselects, floats outputs, reports standby
// - chip select low selects the device and enables instruction and data transfer
// - no instruction is accepted until a high-to-low select transition after power-up
// - input data is ignored while chip select is high
// - single mode captures the serial input lane on rising clock edges
// - single mode drives the serial output lane from falling clock edges
// - dual and quad use lanes 0 and 1 both ways, rise in, fall out
// - quad transfers use write protect as lane 2 and pause as lane 3
// - write-disable set and protect pin low refuses protected status writes
// - write-disable clear allows status writes whatever the protect pin
// - quad enable set disables write protect, pin is only lane 2
// - quad enable set disables pause and reset on the shared pin
// - without dedicated reset, select bit picks pause (0) or reset (1)
// - enabled dedicated reset makes the shared pin always pause
// - disabled dedicated reset lets the select bit choose pause or reset
// - pause while selected suspends transfer without losing partial data
// - pause and select low keep the serial output lane floating
// - releasing pause resumes the transfer where it stopped
// - hardware reset low floats outputs and resets the link, high is normal
// - function register bit 0 set disables the dedicated reset pin
// - clock modes 0 and 3 both capture on rise and drive on fall
`timescale 1ns/10ps
`default_nettype none

module sfp_pin_ctrl
   import sfp_pkg::*;
(
   // system clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // link pins
   input  wire logic       sck,
   input  wire logic       csN,
   input  wire logic       dedResetN,
   input  wire logic [3:0] laneIn,
   output var  logic [3:0] laneOut,
   output var  logic [3:0] laneOe,
   // configuration
   input  wire logic       hasDedReset,
   input  wire logic       funcResetDisable,
   input  wire logic       pin3FunctionSelect,
   input  wire logic [1:0] laneWidth,
   input  wire logic       driveData,
   // received bytes
   output var  logic [7:0] rxByte,
   output var  logic       rxValid,
   // bytes to send
   input  wire logic [7:0] txByte,
   input  wire logic       txLoad,
   output var  logic       txReady,
   // protected status bits
   input  wire logic       statusWrStb,
   input  wire logic [5:0] statusWrData,
   output var  logic [5:0] statusBits,
   output var  logic       statusWrRefused,
   // state
   output var  logic       selected,
   output var  logic       standby,
   output var  logic       instrArmed,
   output var  logic       hwResetActive,
   output var  logic       pauseActive
);

   // ==================================================
   // pin function decode
   logic qe;
   logic pin3Reset;
   logic dedResetOn;
   logic hwResetNow;
   logic holdNow;
   logic frameRstN;

   assign qe         = statusBits[ST_QE];
   assign dedResetOn = ded_reset_on(hasDedReset, funcResetDisable);
   assign pin3Reset  = pin3_is_reset(qe, hasDedReset, funcResetDisable,
                                     pin3FunctionSelect);
   // quad enable takes both pause and reset away from the shared pin
   assign holdNow    = !qe && !pin3Reset && !csN && !laneIn[3];
   assign hwResetNow = (dedResetOn && !dedResetN) || (pin3Reset && !laneIn[3]);
   // the link side lives only inside a frame: select high or hardware reset clears it
   assign frameRstN  = rst_b && !csN && !hwResetNow;

   // ==================================================
   // system side synchronisers
   logic       csS;
   logic       wpS;
   logic       hwS;
   logic       holdS;
   logic       rxTogS;
   logic       ackTogS;
   logic       ackTog_r;

   sfp_sync2 #(.W(5)) uSyncSys (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({csN, laneIn[2], hwResetNow, holdNow, ackTog_r}),
      .q     ({csS, wpS, hwS, holdS, ackTogS})
   );

   // ==================================================
   // select tracking and power-up arming
   logic sawHigh_r;
   logic armed_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sawHigh_r <= 1'b0;
         armed_r   <= 1'b0;
      end else begin
         if (csS) begin
            sawHigh_r <= 1'b1;
         end
         if (sawHigh_r && !csS) begin
            armed_r <= 1'b1;
         end
      end
   end

   assign selected      = !csS;
   assign standby       = csS;
   assign instrArmed    = armed_r;
   assign hwResetActive = hwS;
   assign pauseActive   = holdS;

   // ==================================================
   // protected status bits
   logic [5:0] status_r;
   logic       refused_r;
   logic       wrAllowed;

   // protect pin counts only while it still is a protect pin
   assign wrAllowed = !status_r[ST_SWD] || status_r[ST_QE] || wpS;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_r  <= STATUS_RST;
         refused_r <= 1'b0;
      end else begin
         refused_r <= statusWrStb && !wrAllowed;
         if (statusWrStb && wrAllowed) begin
            status_r <= statusWrData;
         end
      end
   end

   assign statusBits      = status_r;
   assign statusWrRefused = refused_r;

   // ==================================================
   // width and direction towards the link
   sfp_width_e widthEff_r;
   logic       drive_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         widthEff_r <= SFP_SINGLE;
         drive_r    <= 1'b0;
      end else begin
         // quad width needs the quad enable, else lanes 2 and 3 keep their pin functions
         widthEff_r <= (sfp_width_e'(laneWidth) == SFP_QUAD && !qe) ? SFP_SINGLE
                                                                   : sfp_width_e'(laneWidth);
         drive_r    <= driveData;
      end
   end

   // ==================================================
   // transmit hand-off, toggle request with held data
   logic [7:0] txHold_r;
   logic       reqTog_r;

   assign txReady = (reqTog_r == ackTogS);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txHold_r <= BYTE_RST;
         reqTog_r <= 1'b0;
      end else if (txLoad && txReady) begin
         txHold_r <= txByte;
         reqTog_r <= !reqTog_r;
      end
   end

   // ==================================================
   // link side synchronisers, run on the serial clock
   logic [1:0] widthS;
   logic       driveS;
   logic       reqTogS;
   sfp_width_e widthL;

   sfp_sync2 #(.W(4)) uSyncLink (
      .clk   (sck),
      .rst_b (frameRstN),
      .d     ({widthEff_r, drive_r, reqTog_r}),
      .q     ({widthS, driveS, reqTogS})
   );

   assign widthL = sfp_width_e'(widthS);

   // ==================================================
   // receive shifter on rising edges
   logic [7:0] rxSh_r;
   logic [3:0] rxCnt_r;
   logic [7:0] rxHold_r;
   logic       rxTog_r;
   logic [7:0] rxShNxt;
   logic [3:0] rxCntNxt;

   assign rxShNxt  = shift_in(rxSh_r, laneIn, widthL);
   assign rxCntNxt = rxCnt_r + width_step(widthL);

   always_ff @(posedge sck or negedge frameRstN) begin
      if (!frameRstN) begin
         rxSh_r  <= BYTE_RST;
         rxCnt_r <= BIT_CNT_RST;
      end else if (!holdNow && !driveS) begin
         rxSh_r  <= rxShNxt;
         rxCnt_r <= (rxCntNxt >= BYTE_BITS) ? BIT_CNT_RST : rxCntNxt;
      end
   end

   // hold and toggle live past the frame so the last byte still crosses
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         rxHold_r <= BYTE_RST;
         rxTog_r  <= 1'b0;
      end else if (frameRstN && !holdNow && !driveS && rxCntNxt >= BYTE_BITS) begin
         rxHold_r <= rxShNxt;
         rxTog_r  <= !rxTog_r;
      end
   end

   // ==================================================
   // transmit shifter on falling edges
   logic [7:0] txSh_r;
   logic [3:0] txCnt_r;
   logic [3:0] out_r;
   logic [3:0] txCntNxt;
   logic [7:0] txCur;

   assign txCur    = (txCnt_r == BIT_CNT_RST) ? txHold_r : txSh_r;
   assign txCntNxt = txCnt_r + width_step(widthL);

   always_ff @(negedge sck or negedge frameRstN) begin
      if (!frameRstN) begin
         txSh_r  <= BYTE_RST;
         txCnt_r <= BIT_CNT_RST;
         out_r   <= LANE_RST;
      end else if (!holdNow && driveS) begin
         case (widthL)
            SFP_DUAL: out_r <= {2'h0, txCur[7:6]};
            SFP_QUAD: out_r <= txCur[7:4];
            default:  out_r <= {2'h0, txCur[7], 1'b0};
         endcase
         txSh_r  <= txCur << width_step(widthL);
         txCnt_r <= (txCntNxt >= BYTE_BITS) ? BIT_CNT_RST : txCntNxt;
      end
   end

   // reads the held byte at a byte start only; request data is stable by then
   always_ff @(negedge sck or negedge rst_b) begin
      if (!rst_b) begin
         ackTog_r <= 1'b0;
      end else if (frameRstN && !holdNow && driveS && txCnt_r == BIT_CNT_RST) begin
         ackTog_r <= reqTogS;
      end
   end

   // ==================================================
   // lane drive enables, cut at once by select, pause and reset
   logic driveOn;

   assign driveOn   = !csN && !hwResetNow && !holdNow && driveS;
   assign laneOut   = out_r;
   assign laneOe[1] = driveOn;
   assign laneOe[0] = driveOn && widthL != SFP_SINGLE;
   assign laneOe[2] = driveOn && widthL == SFP_QUAD;
   assign laneOe[3] = driveOn && widthL == SFP_QUAD;

   // ==================================================
   // received byte towards the command logic
   logic       rxTogD_r;
   logic [7:0] rxByte_r;
   logic       rxValid_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxTogD_r  <= 1'b0;
         rxByte_r  <= BYTE_RST;
         rxValid_r <= 1'b0;
      end else begin
         rxTogD_r  <= rxTogS;
         rxValid_r <= (rxTogS != rxTogD_r) && armed_r;
         if (rxTogS != rxTogD_r) begin
            rxByte_r <= rxHold_r;
         end
      end
   end

   sfp_sync2 #(.W(1)) uSyncRx (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (rxTog_r),
      .q     (rxTogS)
   );

   assign rxByte  = rxByte_r;
   assign rxValid = rxValid_r;

   // ==================================================
   // checks
   a_desel_float: assert property (@(posedge clk) disable iff (!rst_b)
      csN |-> laneOe == 4'h0)
      else $error("lanes driven while deselected");

   a_pause_float: assert property (@(posedge clk) disable iff (!rst_b)
      (holdNow && !csN) |-> !laneOe[1])
      else $error("output lane driven during pause");

   a_hwrst_float: assert property (@(posedge clk) disable iff (!rst_b)
      hwResetNow |-> laneOe == 4'h0)
      else $error("lanes driven during hardware reset");

   a_wr_refused: assert property (@(posedge clk) disable iff (!rst_b)
      (statusWrStb && status_r[ST_SWD] && !status_r[ST_QE] && !wpS)
      |=> refused_r && $stable(status_r))
      else $error("protected status write not refused");

   a_wr_open: assert property (@(posedge clk) disable iff (!rst_b)
      (statusWrStb && !status_r[ST_SWD]) |=> status_r == $past(statusWrData) && !refused_r)
      else $error("unprotected status write lost");

   a_qe_no_wp: assert property (@(posedge clk) disable iff (!rst_b)
      (statusWrStb && status_r[ST_QE]) |=> !refused_r)
      else $error("write refused with quad enable set");

   a_qe_no_rst: assert property (@(posedge clk) disable iff (!rst_b)
      qe |-> !pin3Reset && !holdNow)
      else $error("shared pin function active with quad enable");

   a_ded_pause: assert property (@(posedge clk) disable iff (!rst_b)
      dedResetOn |-> !pin3Reset)
      else $error("shared pin reset while dedicated reset on");

   a_arm_gate: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(armed_r) |-> !rxValid_r)
      else $error("byte delivered before arming");

   a_rx_deliver: assert property (@(posedge clk) disable iff (!rst_b)
      (rxTogS != rxTogD_r && armed_r) |=> rxValid_r && rxByte_r == $past(rxHold_r))
      else $error("received byte not delivered");

   a_pause_freeze: assert property (@(posedge sck) disable iff (!frameRstN)
      holdNow |=> $stable(rxCnt_r) && $stable(rxSh_r))
      else $error("shifting during pause");

   c_rx_byte:   cover property (@(posedge clk) disable iff (!rst_b) rxValid_r);
   c_refused:   cover property (@(posedge clk) disable iff (!rst_b) refused_r);
   c_pause_mid: cover property (@(posedge sck) disable iff (!frameRstN) holdNow && rxCnt_r != BIT_CNT_RST);
   c_quad_out:  cover property (@(posedge clk) disable iff (!rst_b) laneOe[3]);

endmodule : sfp_pin_ctrl

`default_nettype wire

// *** test/sfp_host_model.sv ***
// spi host model that drives the link pins of the flash front end
`timescale 1ns/10ps
`default_nettype none

module sfp_host_model (
   // link clock and select
   output var  logic       sck,
   output var  logic       csN,
   // data lanes
   input  wire logic [3:0] laneOut,
   input  wire logic [3:0] laneOe,
   output var  logic [3:0] laneIn
);
   logic [3:0] drv;
   logic       mode3;
   logic [7:0] got;
   event       gotEv;

   // select is held low from power-up so the arming check has work to do
   initial begin
      sck = 1'b0;
      csN = 1'b0;
      drv = 4'hC;
      mode3 = 1'b0;
   end

   // ==================================================
   // wire level: an enabled device lane wins over the host
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         laneIn[i] = laneOe[i] ? laneOut[i] : drv[i];
      end
   end

   // ==================================================
   // one serial clock: lanes change after the fall, both sides sample at the rise
   task automatic cyc(input logic [3:0] d, output logic [3:0] s);
      if (mode3) #7.5 sck = 1'b0;
      drv = d;
      #7.5 s = laneIn;
      sck = 1'b1;
      if (!mode3) #7.5 sck = 1'b0;
   endtask : cyc

   task automatic start(input logic m3);
      mode3 = m3;
      sck = m3;
      #20 csN = 1'b0;
      #10;
   endtask : start

   // released lanes 0 and 1 show the inverse, lanes 2 and 3 go high, so stale data cannot pass
   task automatic stop();
      #10 csN = 1'b1;
      drv = {2'b11, ~drv[1:0]};
      #30;
   endtask : stop

   task automatic sendByte(input logic [7:0] b, input int w);
      logic [3:0] s;
      for (int k = 8 - w; k >= 0; k -= w) begin
         cyc(w == 4 ? b[k+:4] : w == 2 ? {2'b11, b[k+:2]} : {3'b110, b[k]}, s);
      end
   endtask : sendByte

   task automatic recvByte(input int w);
      logic [3:0] s;
      got = 8'h00;
      for (int k = 0; k < 8; k += w) begin
         cyc(4'hC, s);
         got = w == 4 ? {got[3:0], s} : w == 2 ? {got[5:0], s[1:0]} : {got[6:0], s[1]};
      end
      ->gotEv;
   endtask : recvByte

endmodule : sfp_host_model
`default_nettype wire

// *** test/sfp_pin_ctrl_bench.sv ***
// self-checking bench for the serial flash pin front end
`timescale 1ns/10ps
`default_nettype none

module sfp_pin_ctrl_bench;
   import sfp_pkg::*;
   logic       clk, rst_b, sck, csN, dedResetN, hasDedReset, funcResetDisable, pin3FunctionSelect;
   logic       driveData, rxValid, txLoad, txReady, statusWrStb, statusWrRefused, stbD;
   logic       selected, standby, instrArmed, hwResetActive, pauseActive;
   logic [3:0] laneIn, laneOut, laneOe;
   logic [1:0] laneWidth;
   logic [7:0] rxByte, txByte, rnd;
   logic [5:0] statusWrData, statusBits, stExp;
   logic [7:0] rxQ[$], txQ[$];
   logic [6:0] stQ[$];
   logic [6:0] stTab[7] = '{7'h2A, 7'h15, 7'h63, 7'h30, 7'h70, 7'h0F, 7'h10};
   int         n_mismatch, num_checks;

   sfp_pin_ctrl DUT (.clk, .rst_b, .sck, .csN, .dedResetN, .laneIn, .laneOut, .laneOe, .hasDedReset,
      .funcResetDisable, .pin3FunctionSelect, .laneWidth, .driveData, .rxByte, .rxValid, .txByte,
      .txLoad, .txReady, .statusWrStb, .statusWrData, .statusBits, .statusWrRefused, .selected,
      .standby, .instrArmed, .hwResetActive, .pauseActive);
   sfp_host_model host (.sck, .csN, .laneOut, .laneOe, .laneIn);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // the protect pin is moved first; it reaches the core through a synchroniser
   task automatic wrStatus(input logic [5:0] d, input logic wp);
      logic refuse;
      host.drv[2] = wp;
      repeat (4) @(posedge clk);
      refuse = stExp[ST_SWD] && !stExp[ST_QE] && !wp;
      if (!refuse) stExp = d;
      stQ.push_back({refuse, stExp});
      statusWrStb <= 1'b1;
      statusWrData <= d;
      @(posedge clk);
      statusWrStb <= 1'b0;
   endtask : wrStatus

   task automatic txFrame(input logic [1:0] wc, input logic m3, input logic pz);
      logic [3:0] s;
      // one edge apart from the previous frame's release of driveData
      @(posedge clk);
      for (int n = 0; n < 100 && txReady !== 1'b1; n++) @(posedge clk);
      check({7'h0, txReady}, 8'h01, "tx ready");
      rnd = lfsr(rnd);
      txQ.push_back(rnd);
      laneWidth <= wc;
      driveData <= 1'b1;
      txLoad <= 1'b1;
      txByte <= rnd;
      @(posedge clk);
      txLoad <= 1'b0;
      host.start(m3);
      repeat (2) host.cyc(4'hC, s);
      if (pz) begin
         host.cyc(4'h4, s);
         check({7'h0, laneOe[1]}, 8'h00, "float on pause");
      end
      host.recvByte(1 << wc);
      check({4'h0, laneOe}, {4'h0, wc == 2'h2 ? 4'hF : wc == 2'h1 ? 4'h3 : 4'h2}, "lane enables");
      host.stop();
      @(posedge clk);
      driveData <= 1'b0;
   endtask : txFrame

   // ==================================================
   // result watchers
   always @(posedge clk) begin
      stbD <= statusWrStb;
      if (rxValid === 1'b1) check(rxByte, rxQ.size() ? rxQ.pop_front() : 8'hXX, "rx byte");
      if (stbD === 1'b1) check({1'b0, statusWrRefused, statusBits}, {1'b0, stQ.pop_front()}, "status");
   end

   always @(host.gotEv) check(host.got, txQ.size() ? txQ.pop_front() : 8'hXX, "tx byte");

   // limitation: a hang is cut off well beyond the expected run of some 3 us
   initial begin
      #300000;
      n_mismatch++;
      end_of_test();
   end

   // ==================================================
   // main sequence
   initial begin
      logic [3:0] s;
      logic       qe, dl, hs, ds, sl, dOn, p3r;
      {rst_b, statusWrStb, txLoad, driveData, hasDedReset, funcResetDisable, pin3FunctionSelect} = 7'h00;
      {dedResetN, laneWidth, statusWrData, txByte, stExp} = {1'b1, 22'h0};
      rnd = 8'h05;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      host.sendByte(8'hA5, 1);
      repeat (6) @(posedge clk);
      check({7'h0, instrArmed}, 8'h00, "armed early");
      host.stop();
      repeat (3) @(posedge clk);
      check({2'h0, standby, selected, laneOe}, 8'h20, "deselect");
      host.start(1'b0);
      repeat (4) host.cyc(4'hD, s);
      host.stop();
      // clocks while deselected must leave no bits that would misalign the next frame
      repeat (4) host.cyc(4'hD, s);
      for (int m = 0; m < 2; m++) begin
         host.start(m[0]);
         repeat (4) @(posedge clk);
         check({5'h0, selected, standby, instrArmed}, 8'h05, "select");
         for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            rxQ.push_back(rnd);
            host.sendByte(rnd, 1);
         end
         host.stop();
      end
      @(posedge clk);
      laneWidth <= 2'h1;
      host.start(1'b0);
      repeat (3) host.cyc(4'h4, s);
      rnd = lfsr(rnd);
      rxQ.push_back(rnd);
      for (int k = 6; k >= 0; k -= 2) begin
         if (k == 2) begin
            repeat (3) host.cyc(4'h5, s);
            check({7'h0, pauseActive}, 8'h01, "pause");
         end
         host.cyc({2'b11, rnd[k+:2]}, s);
      end
      host.stop();
      foreach (stTab[i]) wrStatus(stTab[i][5:0], stTab[i][6]);
      for (int t = 0; t < 3; t++) txFrame(t[1:0], t[0], 1'b0);
      wrStatus(6'h00, 1'b1);
      txFrame(2'h0, 1'b0, 1'b1);
      host.start(1'b0);
      for (int i = 0; i < 32; i++) begin
         {qe, dl, hs, ds, sl} = i[4:0];
         if (i[3:0] == 4'h0) wrStatus({1'b0, qe, 4'h0}, 1'b1);
         @(posedge clk);
         hasDedReset <= hs;
         funcResetDisable <= ds;
         pin3FunctionSelect <= sl;
         dedResetN <= !dl;
         host.drv[3] = 1'b0;
         repeat (5) @(posedge clk);
         dOn = hs && !ds;
         p3r = !qe && !dOn && sl;
         check({6'h0, pauseActive && !dl, hwResetActive}, {6'h0, !qe && !p3r && !dl, p3r || (dOn && dl)},
            "pin function");
      end
      host.drv[3] = 1'b1;
      host.stop();
      repeat (10) @(posedge clk);
      check(8'(rxQ.size() + txQ.size() + stQ.size()), 8'h00, "results left over");
      end_of_test();
   end

endmodule : sfp_pin_ctrl_bench
`default_nettype wire
